// ---- logic/slc_tx_control.sv ----
// serial link transmit control: quick configuration, link control registers, tail lfsr, sync handling
`timescale 1ns/1ps
`default_nettype none
module slc_tx_control #(
  parameter int CONT_W = 16,  // sample container width
  parameter int RES_W  = 12,  // converter resolution
  parameter int CS_W   = 0,   // control bits per sample
  parameter int TAIL_W = CONT_W - RES_W - CS_W  // tail bits per sample
) (
  input  wire logic                     core_clk,            // 25 mhz clock
  input  wire logic                     nrst,                // async reset, active low
  input  wire logic [7:0]               reg_addr,            // register offset
  input  wire logic [7:0]               reg_wdata,           // write data
  input  wire logic                     reg_wr,              // write strobe
  input  wire logic                     reg_rd,              // read strobe
  output logic      [7:0]               reg_rdata,           // read data, one cycle after strobe
  input  wire logic                     sync_request_input,  // sync request pin, active low
  output slc_pkg::slc_link_ctrl_type    link_ctrl,           // datapath controls
  output slc_pkg::slc_cfg_type          link_cfg,            // mode, lanes and link fields
  output logic      [TAIL_W-1:0]        tail_bits            // tail fill per sample
);
  import slc_pkg::*;

  // register state
  logic [7:0]  ctrl1;        // link_control_one
  logic [7:0]  ctrl2;        // sync control
  slc_cfg_type cfg;          // fields touched by quick codes
  logic [7:0]  next_ctrl1;
  logic [7:0]  next_ctrl2;
  slc_cfg_type next_cfg;
  logic [7:0]  next_rdata;

  // quick code decode; valid flag low for codes with no effect
  function automatic logic quick_decode(input logic [7:0] code, output slc_cfg_type val);
    logic ok;
    ok          = 1'b1;
    val.mode    = MODE_DUAL_HIGH;
    val.lanes   = LANES_ONE;
    val.field_a = QUICK_FIELD;
    val.field_b = QUICK_FIELD;
    case (code)
      8'hc2: begin  // [RQ1]
        val.mode  = MODE_DUAL_HIGH;
        val.lanes = LANES_TWO;
      end
      8'hc4: begin  // [RQ2]
        val.mode  = MODE_DUAL_HIGH;
        val.lanes = LANES_FOUR;
      end
      8'hd1: begin  // [RQ3]
        val.mode  = MODE_DUAL_LOW;
        val.lanes = LANES_ONE;
      end
      8'hd2: begin  // [RQ4]
        val.mode  = MODE_DUAL_LOW;
        val.lanes = LANES_TWO;
      end
      8'he1: begin  // [RQ5]
        val.mode  = MODE_DUAL_MIXED;
        val.lanes = LANES_ONE;
      end
      8'he2: begin  // [RQ5]
        val.mode  = MODE_DUAL_MIXED;
        val.lanes = LANES_TWO;
      end
      8'he4: begin  // [RQ5]
        val.mode  = MODE_DUAL_MIXED;
        val.lanes = LANES_FOUR;
      end
      default: begin
        ok = 1'b0;  // [RQ6]
      end
    endcase
    return ok;
  endfunction

  // one lfsr step, polynomial 1 + x^28 + x^31
  function automatic logic [LFSR_W-1:0] lfsr_step(input logic [LFSR_W-1:0] s);
    return {s[LFSR_W-2:0], s[30] ^ s[27]};
  endfunction

  // register write and read decode
  always_comb begin
    slc_cfg_type qval;
    logic        qok;
    qval       = cfg;
    next_ctrl1 = ctrl1;
    next_ctrl2 = ctrl2;
    next_cfg   = cfg;
    next_rdata = reg_rdata;
    qok        = quick_decode(reg_wdata, qval);
    if (reg_wr) begin
      case (reg_addr)
        OFS_QUICK_CFG: begin
          // all four fields land in the same edge; later writes override them
          if (qok) next_cfg = qval;  // [RQ23] [RQ6]
        end
        OFS_LINK_CTRL1:   next_ctrl1 = reg_wdata & CTRL1_WR_MASK;  // [RQ22]
        OFS_LINK_CTRL2:   next_ctrl2 = reg_wdata & CTRL2_WR_MASK;
        OFS_MODE:         next_cfg.mode = reg_wdata[3:0];
        OFS_LANES:        next_cfg.lanes = reg_wdata[4:0];
        OFS_LINK_FIELD_A: next_cfg.field_a = reg_wdata[4:0];
        OFS_LINK_FIELD_B: next_cfg.field_b = reg_wdata[4:0];
        default: begin
          // unmapped write ignored
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_QUICK_CFG:    next_rdata = 8'h00;  // self clearing, nothing stored [RQ20]
        OFS_LINK_CTRL1:   next_rdata = ctrl1;  // bit 7 always zero [RQ22]
        OFS_LINK_CTRL2:   next_rdata = ctrl2;
        OFS_MODE:         next_rdata = {4'h0, cfg.mode};
        OFS_LANES:        next_rdata = {3'h0, cfg.lanes};
        OFS_LINK_FIELD_A: next_rdata = {3'h0, cfg.field_a};
        OFS_LINK_FIELD_B: next_rdata = {3'h0, cfg.field_b};
        default:          next_rdata = 8'h00;  // unmapped reads zero
      endcase
    end
  end

  // register storage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1         <= RST_LINK_CTRL1;  // [RQ19]
      ctrl2         <= RST_LINK_CTRL2;
      cfg.mode      <= RST_MODE;
      cfg.lanes     <= RST_LANES;
      cfg.field_a   <= RST_LINK_FIELD;
      cfg.field_b   <= RST_LINK_FIELD;
      reg_rdata     <= 8'h00;
    end else begin
      ctrl1     <= next_ctrl1;
      ctrl2     <= next_ctrl2;
      cfg       <= next_cfg;
      reg_rdata <= next_rdata;
    end
  end

  // sync request synchroniser; pin is asynchronous to core_clk
  logic [2:0] sync_sr;       // three stage shift
  logic       sync_level;    // filtered pin level
  logic [2:0] next_sync_sr;
  logic       next_sync_level;

  always_comb begin
    next_sync_sr    = {sync_sr[1:0], sync_request_input};
    next_sync_level = sync_level;
    // stage one only feeds stage two; change taken when two and three agree
    if (sync_sr[1] == sync_sr[2]) next_sync_level = sync_sr[2];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync_sr    <= 3'h7;  // idle high: no request
      sync_level <= 1'b1;
    end else begin
      sync_sr    <= next_sync_sr;
      sync_level <= next_sync_level;
    end
  end

  // tail lfsr; held at seed while the link is powered down
  logic [LFSR_W-1:0] lfsr;
  logic [LFSR_W-1:0] next_lfsr;
  logic [TAIL_W-1:0] next_tail;

  always_comb begin
    next_lfsr = lfsr;
    next_tail = '0;  // zero padding when lfsr fill is off [RQ7]
    if (ctrl1[BIT_POWER_DOWN]) begin
      next_lfsr = LFSR_SEED;  // [RQ16]
    end else if (ctrl1[BIT_TAIL_PN]) begin
      next_lfsr = lfsr_step(lfsr);  // [RQ7]
      // only n' - n - cs bits leave per sample [RQ8]
      next_tail = lfsr[TAIL_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lfsr      <= LFSR_SEED;
      tail_bits <= '0;
    end else begin
      lfsr      <= next_lfsr;
      tail_bits <= next_tail;
    end
  end

  // datapath controls, registered so the datapath sees clean levels
  slc_link_ctrl_type next_ctrl;
  logic              sync_req;  // request after polarity option

  always_comb begin
    logic [1:0] align_mode;
    logic       up;
    align_mode = ctrl1[BIT_ALIGN_HI:BIT_ALIGN_LO];
    up         = ~ctrl1[BIT_POWER_DOWN];
    // pin is active low; invert option flips the sense
    sync_req   = ~sync_level ^ ctrl2[BIT_SYNC_INVERT];
    next_ctrl.link_reset      = ctrl1[BIT_POWER_DOWN];                  // [RQ16]
    next_ctrl.link_clk_en     = up;                                     // [RQ16]
    next_ctrl.tail_pn_en      = up & ctrl1[BIT_TAIL_PN];                // [RQ7]
    next_ctrl.test_sample_en  = up & ctrl1[BIT_TEST_SAMPLE];            // [RQ9]
    // lane sync relies on software keeping insertion enabled
    next_ctrl.lane_sync_en    = up & ctrl1[BIT_LANE_SYNC];              // [RQ11] [RQ12]
    next_ctrl.k28_7_only      = ~ctrl1[BIT_LANE_SYNC];                  // [RQ10]
    next_ctrl.align_insert_en = up & ~ctrl1[BIT_FRAME_ALIGN_INSERT_DISABLE_DISABLE];          // [RQ15]
    // reserved 10 treated as off
    next_ctrl.ilas_en         = up & (align_mode == ALIGN_ON);          // [RQ13]
    next_ctrl.ilas_repeat     = up & (align_mode == ALIGN_REPEAT);      // [RQ14]
    next_ctrl.send_k28_5      = up & sync_req &
                                (ctrl2[BIT_SYNC_MODE_HI:BIT_SYNC_MODE_LO] != SYNC_PINS_OFF);  // [RQ18] [RQ21]
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      link_ctrl <= '0;
      link_cfg  <= '0;
    end else begin
      link_ctrl <= next_ctrl;
      link_cfg  <= cfg;
    end
  end

endmodule
`default_nettype wire

// ---- include/slc_pkg.sv ----
// package of register map, field layouts and carriers for the serial link transmit control
// Notes on behaviour
// RQ1 - code c2: mode c, lanes 1, fields f
// RQ2 - code c4: mode c, lanes 3, fields f
// RQ3 - code d1: mode d, lanes 0, fields f
// RQ4 - code d2: mode d, lanes 1, fields f
// RQ5 - codes e1/e2/e4: mode e, lanes 0/1/3
// RQ6 - unknown quick codes change nothing
// RQ7 - bit 6 picks zero or lfsr tail fill
// RQ8 - tail count is container minus resolution minus control
// RQ9 - bit 5 sends transport test samples
// RQ10 - no lane sync: only k28.7 alignment
// RQ11 - lane sync: k28.3 or k28.7 alignment
// RQ12 - software keeps insert disable clear with sync
// RQ13 - bits 3:2 00 off, 01 on, 10 reserved
// RQ14 - mode 11 repeats alignment sequence always
// RQ15 - bit 1 stops alignment character insertion
// RQ16 - bit 0 holds link reset, clock gated
// RQ17 - software powers down around configuration changes
// RQ18 - enabled link: sync request drives k28.5
// RQ19 - link control one resets to 14
// RQ20 - quick register self clears, reads zero
// RQ21 - sync mode 11 ignores request pins
// RQ22 - bit 7 ignores writes, reads zero
// RQ23 - quick code fields update together, overridable
`default_nettype none
package slc_pkg;

  // register offsets
  localparam logic [7:0] OFS_QUICK_CFG    = 8'h5e;  // self clearing quick configuration
  localparam logic [7:0] OFS_LINK_CTRL1   = 8'h5f;  // link_control_one
  localparam logic [7:0] OFS_LINK_CTRL2   = 8'h60;  // sync mode and invert
  localparam logic [7:0] OFS_MODE         = 8'h63;  // converter mode field [3:0]
  localparam logic [7:0] OFS_LANES        = 8'h6e;  // lane count minus one [4:0]
  localparam logic [7:0] OFS_LINK_FIELD_A = 8'h72;  // further link field [4:0]
  localparam logic [7:0] OFS_LINK_FIELD_B = 8'h73;  // further link field [4:0]

  // reset values
  localparam logic [7:0] RST_LINK_CTRL1   = 8'h14;  // lane sync and alignment sequence on
  localparam logic [7:0] RST_LINK_CTRL2   = 8'h00;
  localparam logic [3:0] RST_MODE         = 4'h0;
  localparam logic [4:0] RST_LANES        = 5'h00;
  localparam logic [4:0] RST_LINK_FIELD   = 5'h00;

  // link_control_one field positions
  localparam int BIT_TAIL_PN      = 6;
  localparam int BIT_TEST_SAMPLE  = 5;
  localparam int BIT_LANE_SYNC    = 4;
  localparam int BIT_ALIGN_HI     = 3;
  localparam int BIT_ALIGN_LO     = 2;
  localparam int BIT_FRAME_ALIGN_INSERT_DISABLE_DISABLE = 1;
  localparam int BIT_POWER_DOWN   = 0;
  localparam logic [7:0] CTRL1_WR_MASK = 8'h7f;  // bit 7 unused

  // link control two field positions
  localparam int BIT_SYNC_MODE_HI = 7;
  localparam int BIT_SYNC_MODE_LO = 6;
  localparam int BIT_SYNC_INVERT  = 5;
  localparam logic [7:0] CTRL2_WR_MASK = 8'he7;  // bits 4:3 unused

  // alignment sequence modes
  localparam logic [1:0] ALIGN_OFF    = 2'h0;
  localparam logic [1:0] ALIGN_ON     = 2'h1;
  localparam logic [1:0] ALIGN_REPEAT = 2'h3;

  // sync modes
  localparam logic [1:0] SYNC_PINS_OFF = 2'h3;

  // quick configuration values
  localparam logic [3:0] MODE_DUAL_HIGH  = 4'hc;
  localparam logic [3:0] MODE_DUAL_LOW   = 4'hd;
  localparam logic [3:0] MODE_DUAL_MIXED = 4'he;
  localparam logic [4:0] LANES_ONE       = 5'h00;
  localparam logic [4:0] LANES_TWO       = 5'h01;
  localparam logic [4:0] LANES_FOUR      = 5'h03;
  localparam logic [4:0] QUICK_FIELD     = 5'h0f;

  // tail lfsr
  localparam int          LFSR_W    = 31;
  localparam logic [30:0] LFSR_SEED = 31'h7fffffff;

  // configuration fields rewritten together
  typedef struct packed {
    logic [3:0] mode;
    logic [4:0] lanes;
    logic [4:0] field_a;
    logic [4:0] field_b;
  } slc_cfg_type;

  // controls handed to the transmit datapath
  typedef struct packed {
    logic       link_reset;         // link held in reset
    logic       link_clk_en;        // link clock gate enable
    logic       tail_pn_en;         // tail bits from lfsr
    logic       test_sample_en;     // transport test samples
    logic       lane_sync_en;       // lane synchronization on
    logic       k28_7_only;         // alignment uses k28.7 only
    logic       align_insert_en;    // alignment characters inserted
    logic       ilas_en;            // one alignment sequence after sync
    logic       ilas_repeat;        // alignment sequence repeated forever
    logic       send_k28_5;         // code group synchronization request
  } slc_link_ctrl_type;

endpackage
`default_nettype wire

// ---- testbench/slc_tx_control_assertions.sv ----
// checker of port relations of the link transmit control
`timescale 1ns/1ps
`default_nettype none
module slc_tx_control_assertions #(
  parameter int TAIL_W = 4  // tail bits per sample
) (
  input wire logic                       core_clk,            // clock
  input wire logic                       nrst,                // async reset
  input wire logic [7:0]                 reg_addr,            // offset
  input wire logic [7:0]                 reg_wdata,           // write data
  input wire logic                       reg_wr,              // write strobe
  input wire logic                       reg_rd,              // read strobe
  input wire logic [7:0]                 reg_rdata,           // read data
  input wire logic                       sync_request_input,  // sync pin
  input wire slc_pkg::slc_link_ctrl_type link_ctrl,           // controls
  input wire slc_pkg::slc_cfg_type       link_cfg,            // config
  input wire logic [TAIL_W-1:0]          tail_bits            // tail fill
);
  import slc_pkg::*;
  logic live;  // first edge after release still samples reset values
  wire  w1 = reg_wr && reg_addr == OFS_LINK_CTRL1;  // control one write
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) live <= 1'b0;
    else live <= 1'b1;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst || !live);
  a_pd_clk_gated: assert property (link_ctrl.link_reset |-> !link_ctrl.link_clk_en)
    else $error("link clock runs in power-down");
  a_pd_no_k285: assert property (link_ctrl.link_reset |-> !link_ctrl.send_k28_5)
    else $error("k28.5 request while powered down");
  a_k287_only: assert property (!link_ctrl.link_reset && !link_ctrl.lane_sync_en |-> link_ctrl.k28_7_only)
    else $error("k28.3 allowed without lane sync");
  a_sync_both: assert property (link_ctrl.lane_sync_en |-> !link_ctrl.k28_7_only)
    else $error("lane sync limited to k28.7");
  a_tail_zero: assert property (!link_ctrl.tail_pn_en [*3] |-> tail_bits == '0)
    else $error("tail bits not zero");
  a_quick_reads_zero: assert property (reg_rd && reg_addr == OFS_QUICK_CFG |=> reg_rdata == 8'h00)
    else $error("quick register read not zero");
  a_bit7_zero: assert property (reg_rd && reg_addr == OFS_LINK_CTRL1 |=> !reg_rdata[7])
    else $error("unused bit reads one");
  a_test_sample: assert property (w1 ##1 !w1 |=> link_ctrl.test_sample_en ==
    ($past(reg_wdata[5], 2) && !$past(reg_wdata[0], 2))) else $error("test sample enable wrong");
  a_align_insert: assert property (w1 ##1 !w1 |=> link_ctrl.align_insert_en ==
    !($past(reg_wdata[1], 2) || $past(reg_wdata[0], 2))) else $error("alignment insertion wrong");
  a_ilas_repeat: assert property (w1 ##1 !w1 |=> link_ctrl.ilas_repeat ==
    ($past(reg_wdata[3:2], 2) == 2'b11 && !$past(reg_wdata[0], 2))) else $error("repeat mode wrong");
endmodule
bind slc_tx_control slc_tx_control_assertions #(.TAIL_W(TAIL_W)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_request_input(sync_request_input),
  .link_ctrl(link_ctrl), .link_cfg(link_cfg), .tail_bits(tail_bits));
`default_nettype wire

// ---- testbench/slc_sync_partner.sv ----
// receiver end model driving the sync request pin
`timescale 1ns/1ps
`default_nettype none
module slc_sync_partner (
  input  wire logic       core_clk,           // device clock
  input  wire logic       want_sync,          // receiver lost alignment
  input  wire logic [3:0] lag,                // cycles before the pin follows
  output var  logic       sync_request_input  // low asks for k28.5
);
  logic [3:0] cnt;  // cycles waited since want_sync changed
  initial begin
    sync_request_input = 1'b1;  // idles high like a pulled-up pin
    cnt = 4'h0;
  end
  // slow receivers follow late; the pin changes just after an edge
  always @(posedge core_clk) begin
    if (!sync_request_input == want_sync) cnt <= 4'h0;
    else if (cnt >= lag) sync_request_input <= #1 !want_sync;
    else cnt <= cnt + 4'h1;
  end
endmodule
`default_nettype wire

// ---- testbench/slc_tx_control_test.sv ----
// self-checking bench of the link transmit control
`timescale 1ns/1ps
`default_nettype none
module slc_tx_control_test;
  import slc_pkg::*;
  logic              core_clk  = 1'b0;  // 25 mhz clock
  logic              nrst      = 1'b0;  // reset, active low
  logic [7:0]        reg_addr  = 8'h00; // offset
  logic [7:0]        reg_wdata = 8'h00; // write data
  logic              reg_wr    = 1'b0;  // write strobe
  logic              reg_rd    = 1'b0;  // read strobe
  logic              want_sync = 1'b0;  // receiver asks to resync
  logic [3:0]        lag       = 4'h0;  // receiver lag
  logic [7:0]        reg_rdata;         // read data
  logic              sync_request_input;// sync pin
  slc_link_ctrl_type link_ctrl;         // controls
  slc_cfg_type       link_cfg;          // config
  logic [3:0]        tail_bits;         // tail fill
  int                n_mismatch = 0;    // failures
  int                n_compared = 0;    // checks made
  always #20 core_clk = ~core_clk;
  slc_tx_control u_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_request_input(sync_request_input),
    .link_ctrl(link_ctrl), .link_cfg(link_cfg), .tail_bits(tail_bits));
  slc_sync_partner u_rx (.core_clk(core_clk), .want_sync(want_sync), .lag(lag),
    .sync_request_input(sync_request_input));
  task automatic chk(input logic [18:0] got, input logic [18:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tk(input int n);  // settle just after an edge
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tk(1);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    tk(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tk(1);
    {reg_rd, reg_addr} = {1'b1, a};
    tk(1);
    reg_rd = 1'b0;
    chk(19'(reg_rdata), 19'(e), "read");
  endtask
  task automatic wt(input logic v);  // bounded wait for the k28.5 request
    for (int i = 0; i < 20 && link_ctrl.send_k28_5 !== v; i++) tk(1);
    chk(19'(link_ctrl.send_k28_5), 19'(v), "k28.5");
  endtask
  task automatic t_reset();
    rd(OFS_LINK_CTRL1, 8'h14);
    rd(8'hff, 8'h00);  // unmapped place reads zero
    chk(19'({link_ctrl.link_clk_en, link_ctrl.lane_sync_en, link_ctrl.ilas_en, link_ctrl.link_reset}),
      19'(4'b1110), "reset");
  endtask
  task automatic t_quick();
    logic [7:0] code [7] = '{8'hc2, 8'hc4, 8'hd1, 8'hd2, 8'he1, 8'he2, 8'he4};
    logic [3:0] md [7] = '{4'hc, 4'hc, 4'hd, 4'hd, 4'he, 4'he, 4'he};
    logic [4:0] ln [7] = '{5'h01, 5'h03, 5'h00, 5'h01, 5'h00, 5'h01, 5'h03};
    wr(OFS_LINK_CTRL1, 8'h15);
    foreach (code[i]) begin
      wr(OFS_QUICK_CFG, code[i]);
      tk(2);
      chk(link_cfg, {md[i], ln[i], 5'h0f, 5'h0f}, "quick");
    end
    rd(OFS_QUICK_CFG, 8'h00);
    wr(OFS_QUICK_CFG, 8'hc2);
    wr(OFS_LANES, 8'h05);  // override right after the quick code
    wr(OFS_QUICK_CFG, 8'h42);
    wr(OFS_QUICK_CFG, 8'hff);
    tk(2);
    chk(link_cfg, {4'hc, 5'h05, 5'h0f, 5'h0f}, "override");
  endtask
  // control value and expected ilas, repeat, insert, tail enable, tail bits
  logic [15:0] code_tab [3] = '{16'h0002, 16'h2008, 16'ha014};
  task automatic t_ctrl();
    logic [30:0] s;  // reference tail lfsr, 1 + x^28 + x^31
    wr(OFS_LINK_CTRL1, 8'hff);
    rd(OFS_LINK_CTRL1, 8'h7f);
    wr(OFS_LINK_CTRL1, 8'h6d);  // change config powered down
    wr(OFS_LINK_CTRL1, 8'h6c);
    tk(2);
    chk(19'({link_ctrl.tail_pn_en, link_ctrl.test_sample_en, link_ctrl.lane_sync_en, link_ctrl.k28_7_only,
      link_ctrl.ilas_repeat, link_ctrl.align_insert_en}), 19'(6'b110111), "ctrl");
    s = 31'h7fffffff;  // seed held through power-down
    s = {s[29:0], s[30] ^ s[27]};  // two edges after power-up the first step shows
    repeat (6) begin
      chk(19'(tail_bits), 19'(s[3:0]), "tail lfsr");
      tk(1);
      s = {s[29:0], s[30] ^ s[27]};
    end
    foreach (code_tab[i]) begin
      wr(OFS_LINK_CTRL1, code_tab[i][7:0]);
      tk(4);
      chk(19'({link_ctrl.ilas_en, link_ctrl.ilas_repeat, link_ctrl.align_insert_en, link_ctrl.tail_pn_en,
        tail_bits}), 19'(code_tab[i][15:8]), "mode");
    end
  endtask
  task automatic t_sync();
    want_sync = 1'b1;
    wt(1'b1);
    want_sync = 1'b0;
    wt(1'b0);
    lag = 4'h6;
    want_sync = 1'b1;
    wt(1'b1);
    wr(OFS_LINK_CTRL2, 8'hc0);
    wt(1'b0);
    wr(OFS_LINK_CTRL2, 8'h80);
    wt(1'b1);
    wr(OFS_LINK_CTRL2, 8'ha0);  // inverted pin sense: low pin no longer asks
    wt(1'b0);
    want_sync = 1'b0;
    wt(1'b1);
    wr(OFS_LINK_CTRL1, 8'h15);
    wt(1'b0);
    chk(19'({link_ctrl.link_reset, link_ctrl.link_clk_en}), 19'(2'b10), "power-down");
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1 nrst = 1'b1;
    t_reset();
    t_quick();
    t_ctrl();
    wr(OFS_LINK_CTRL1, 8'h14);
    t_sync();
    conclude();
  end
  initial begin  // cut a hang well past the expected run
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
